// [core/rnq_pin_qualifier.sv]
// reset and non-maskable interrupt pin qualifier
`timescale 1ns/1ps
`default_nettype none
module rnq_pin_qualifier (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// pins
	input wire logic i_reset_pin,
	input wire logic i_nmi_pin,
	input wire logic i_nmi_pin_driven,
	input wire logic i_external_code_select,
	// power mode requests from the core
	input wire logic i_idle_req,
	input wire logic i_pdown_req,
	// results
	output logic o_port_force_reset,
	output logic o_chip_reset,
	output logic o_nmi_pulse,
	output logic o_code_onchip,
	output logic o_idle,
	output logic o_pdown
);
	// two-stage synchronisers for the asynchronous pins
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic nmi_meta_ff;
	logic nmi_sync_ff;
	logic drv_meta_ff;
	logic drv_sync_ff;
	logic strap_meta_ff;
	logic strap_sync_ff;
	logic nmi_level;

	// qualified results
	logic chip_reset_ff;
	logic nmi_pulse_ff;
	logic code_sel_ff;

	// power mode
	rnq_pkg::rnq_pm_t pm_ff;
	rnq_pkg::rnq_pm_t nxt_pm;
	logic idle_ff;
	logic pdown_ff;

	// true when the power mode equals the mode asked about
	function automatic logic pm_is(input rnq_pkg::rnq_pm_t mode, input rnq_pkg::rnq_pm_t want);
		return mode == want;
	endfunction : pm_is

	rnq_qual_if rst_q ();
	rnq_qual_if nmi_q ();

	// pin forcing is purely combinational so it works with no clock
	assign o_port_force_reset = i_reset_pin;

	// undriven pin behaves as pulled down
	assign nmi_level = nmi_sync_ff & drv_sync_ff;

	// reset pin synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else if (i_ce) begin
			rst_meta_ff <= i_reset_pin;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// interrupt pin synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			nmi_meta_ff <= 1'b0;
			nmi_sync_ff <= 1'b0;
		end else if (i_ce) begin
			nmi_meta_ff <= i_nmi_pin;
			nmi_sync_ff <= nmi_meta_ff;
		end
	end

	// interrupt pin driven flag synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			drv_meta_ff <= 1'b0;
			drv_sync_ff <= 1'b0;
		end else if (i_ce) begin
			drv_meta_ff <= i_nmi_pin_driven;
			drv_sync_ff <= drv_meta_ff;
		end
	end

	// code-select strap synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			strap_meta_ff <= 1'b0;
			strap_sync_ff <= 1'b0;
		end else if (i_ce) begin
			strap_meta_ff <= i_external_code_select;
			strap_sync_ff <= strap_meta_ff;
		end
	end

	// qualifier links
	assign rst_q.level = rst_sync_ff;
	assign rst_q.enable = 1'b1;
	assign nmi_q.level = nmi_level;
	// no interrupt qualification while the chip sits in reset
	assign nmi_q.enable = !chip_reset_ff;

	// reset pin hold counter
	rnq_hold_counter #(
		.TARGET(rnq_pkg::RST_TARGET)
	) u_rst_cnt (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.q(rst_q)
	);

	// interrupt pin hold counter
	rnq_hold_counter #(
		.TARGET(rnq_pkg::NMI_TARGET)
	) u_nmi_cnt (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.q(nmi_q)
	);

	// chip reset holds while the pin stays qualified high
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			chip_reset_ff <= 1'b0;
		end else if (i_ce) begin
			chip_reset_ff <= rst_q.qualified;
		end
	end

	// one pulse per qualified high period of the interrupt pin
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			nmi_pulse_ff <= 1'b0;
		end else if (i_ce) begin
			nmi_pulse_ff <= nmi_q.fire;
		end else begin
			nmi_pulse_ff <= 1'b0;
		end
	end

	// strap caught while chip reset is active, held once it ends
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			code_sel_ff <= rnq_pkg::CODE_SEL_RESET;
		end else if (i_ce && chip_reset_ff) begin
			code_sel_ff <= strap_sync_ff;
		end
	end

	// next power mode; chip reset always wins
	always_comb begin
		nxt_pm = pm_ff;
		case (pm_ff)
			rnq_pkg::RNQ_PM_RUN: begin
				if (i_pdown_req) begin
					nxt_pm = rnq_pkg::RNQ_PM_PDOWN;
				end else if (i_idle_req) begin
					nxt_pm = rnq_pkg::RNQ_PM_IDLE;
				end
			end
			rnq_pkg::RNQ_PM_IDLE: begin
				if (i_pdown_req) begin
					nxt_pm = rnq_pkg::RNQ_PM_PDOWN;
				end
			end
			rnq_pkg::RNQ_PM_PDOWN: begin
				nxt_pm = rnq_pkg::RNQ_PM_PDOWN;
			end
			default: begin
				nxt_pm = rnq_pkg::RNQ_PM_RUN;
			end
		endcase
		if (chip_reset_ff) begin
			nxt_pm = rnq_pkg::RNQ_PM_RUN;
		end
	end

	// power mode state
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pm_ff <= rnq_pkg::RNQ_PM_RUN;
		end else if (i_ce) begin
			pm_ff <= nxt_pm;
		end
	end

	// mode flags registered alongside the state
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			idle_ff <= 1'b0;
			pdown_ff <= 1'b0;
		end else if (i_ce) begin
			idle_ff <= pm_is(nxt_pm, rnq_pkg::RNQ_PM_IDLE);
			pdown_ff <= pm_is(nxt_pm, rnq_pkg::RNQ_PM_PDOWN);
		end
	end

	// outputs
	assign o_chip_reset = chip_reset_ff;
	assign o_nmi_pulse = nmi_pulse_ff;
	assign o_code_onchip = code_sel_ff;
	assign o_idle = idle_ff;
	assign o_pdown = pdown_ff;
endmodule : rnq_pin_qualifier
`default_nettype wire

// [core/rnq_pkg.sv]
// constants shared by the reset and interrupt pin qualifier
package rnq_pkg;
	// oscillator periods the reset pin must stay high
	localparam int unsigned RST_HOLD_PERIODS = 64;
	// oscillator periods the interrupt pin must stay high
	localparam int unsigned NMI_HOLD_PERIODS = 24;
	// one oscillator period is one i_ref_clk cycle (50 MHz, 20 ns)
	localparam int unsigned OSC_PERIOD_PS = 20000;
	localparam int unsigned CLK_PERIOD_PS = 20000;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned NMI_HOLD_CYC = (NMI_HOLD_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W = 7;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
	localparam logic [CNT_W-1:0] RST_TARGET = CNT_W'(RST_HOLD_CYC);
	localparam logic [CNT_W-1:0] NMI_TARGET = CNT_W'(NMI_HOLD_CYC);
	// reset value of the held code-select strap
	localparam logic CODE_SEL_RESET = 1'b0;

	// power mode of the chip
	typedef enum logic [1:0] {
		RNQ_PM_RUN = 2'b00,
		RNQ_PM_IDLE = 2'b01,
		RNQ_PM_PDOWN = 2'b10
	} rnq_pm_t;
endpackage : rnq_pkg

// [core/rnq_qual_if.sv]
// interface carrying one pin qualifier's sample and result
`timescale 1ns/1ps
`default_nettype none
interface rnq_qual_if;
	logic level;
	logic enable;
	logic qualified;
	logic fire;
	modport owner (output level, output enable, input qualified, input fire);
	modport counter (input level, input enable, output qualified, output fire);
endinterface : rnq_qual_if
`default_nettype wire

// [core/rnq_hold_counter.sv]
// counts consecutive high samples of one qualified pin
`timescale 1ns/1ps
`default_nettype none
module rnq_hold_counter #(
	parameter logic [rnq_pkg::CNT_W-1:0] TARGET = rnq_pkg::RST_TARGET
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// qualifier link
	rnq_qual_if.counter q
);
	logic [rnq_pkg::CNT_W-1:0] count_ff;
	logic qualified_ff;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			count_ff <= rnq_pkg::CNT_ZERO;
		end else if (i_ce) begin
			if (!q.level || !q.enable) begin
				count_ff <= rnq_pkg::CNT_ZERO;
			end else if (count_ff != TARGET) begin
				count_ff <= count_ff + rnq_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			qualified_ff <= 1'b0;
		end else if (i_ce) begin
			qualified_ff <= q.level && q.enable && (count_ff == TARGET - rnq_pkg::CNT_ONE || count_ff == TARGET);
		end
	end

	assign q.qualified = qualified_ff;
	// high in the one cycle whose closing edge completes the hold count
	assign q.fire = q.level && q.enable && (count_ff == TARGET - rnq_pkg::CNT_ONE);
endmodule : rnq_hold_counter
`default_nettype wire

// [testbench/rnq_pin_qualifier_assertions.sv]
// checker for the pin qualifier ports
`timescale 1ns/1ps
`default_nettype none
module rnq_pin_qualifier_assertions (
	// watched ports
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_reset_pin,
	input wire logic i_nmi_pin,
	input wire logic i_nmi_pin_driven,
	input wire logic o_port_force_reset,
	input wire logic o_chip_reset,
	input wire logic o_nmi_pulse,
	input wire logic o_code_onchip,
	input wire logic o_idle,
	input wire logic o_pdown
);
	logic [6:0] rcnt_ff;
	logic [6:0] ncnt_ff;
	// consecutive high samples, saturating
	always_ff @(posedge i_ref_clk) rcnt_ff <= (i_srst || !i_reset_pin) ? 7'h00 : rcnt_ff + {6'h00, rcnt_ff != 7'h7f};
	always_ff @(posedge i_ref_clk) ncnt_ff <= (i_srst || !(i_nmi_pin && i_nmi_pin_driven)) ? 7'h00 :
		ncnt_ff + {6'h00, ncnt_ff != 7'h7f};
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	sequence s_pin_gone;
		!i_reset_pin [*5];
	endsequence
	sequence s_idle_strap;
		!o_chip_reset [*3];
	endsequence
	a_port_force_now: assert property (o_port_force_reset == i_reset_pin) else $error("port force wrong");
	a_rst_not_early: assert property ($rose(o_chip_reset) |-> rcnt_ff >= 7'h40) else $error("early reset");
	a_rst_in_time: assert property (rcnt_ff == 7'h48 |-> o_chip_reset) else $error("reset missing");
	a_rst_released: assert property (s_pin_gone |-> !o_chip_reset) else $error("reset stuck");
	a_nmi_not_early: assert property ($rose(o_nmi_pulse) |-> ncnt_ff >= 7'h18) else $error("early nmi");
	a_nmi_one_cycle: assert property (o_nmi_pulse |=> !o_nmi_pulse) else $error("nmi too long");
	a_wake_to_run: assert property (o_chip_reset |=> !o_idle && !o_pdown) else $error("no wake");
	a_strap_held: assert property (s_idle_strap |-> $stable(o_code_onchip)) else $error("strap moved");
endmodule : rnq_pin_qualifier_assertions
bind rnq_pin_qualifier rnq_pin_qualifier_assertions u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
	.i_reset_pin(i_reset_pin), .i_nmi_pin(i_nmi_pin), .i_nmi_pin_driven(i_nmi_pin_driven),
	.o_port_force_reset(o_port_force_reset), .o_chip_reset(o_chip_reset), .o_nmi_pulse(o_nmi_pulse),
	.o_code_onchip(o_code_onchip), .o_idle(o_idle), .o_pdown(o_pdown));
`default_nettype wire

// [testbench/rnq_pin_source.sv]
// model of the external reset circuit and interrupt source
`timescale 1ns/1ps
`default_nettype none
module rnq_pin_source (
	input wire logic i_ref_clk,
	output logic o_reset_pin = 1'b0,
	output logic o_nmi_pin = 1'b0,
	output logic o_nmi_driven = 1'b1
);
	// one high run of n periods; undriven interrupt pin left floating high
	task automatic pulse(input logic nmi, input logic drv, input int n);
		@(posedge i_ref_clk);
		if (nmi) o_nmi_pin <= 1'b1; else o_reset_pin <= 1'b1;
		o_nmi_driven <= drv;
		repeat (n) @(posedge i_ref_clk);
		o_reset_pin <= 1'b0;
		o_nmi_pin <= 1'b0;
		o_nmi_driven <= 1'b1;
	endtask : pulse
endmodule : rnq_pin_source
`default_nettype wire

// [testbench/reset_and_nmi_pin_qualifier_test.sv]
// self-checking bench for the pin qualifier
`timescale 1ns/1ps
`default_nettype none
module reset_and_nmi_pin_qualifier_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic code_sel = 1'b0;
	logic idle_req = 1'b0;
	logic pdown_req = 1'b0;
	logic ce = 1'b1;
	wire logic rst_pin, nmi_pin, nmi_drv, force_rst, chip_rst, nmi_pulse, code_on, idle, pdown;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	int npulse = 0;
	int rst_seen = 0;
	always #10 clk = ~clk;
	rnq_pin_source src (.i_ref_clk(clk), .o_reset_pin(rst_pin), .o_nmi_pin(nmi_pin), .o_nmi_driven(nmi_drv));
	rnq_pin_qualifier dut (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_reset_pin(rst_pin), .i_nmi_pin(nmi_pin),
		.i_nmi_pin_driven(nmi_drv), .i_external_code_select(code_sel), .i_idle_req(idle_req),
		.i_pdown_req(pdown_req), .o_port_force_reset(force_rst), .o_chip_reset(chip_rst),
		.o_nmi_pulse(nmi_pulse), .o_code_onchip(code_on), .o_idle(idle), .o_pdown(pdown));
	task automatic check(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles++;
		if (nmi_pulse === 1'b1) npulse++;
		if (chip_rst === 1'b1) rst_seen++;
		if (cycles == 32'h1388) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic t_reset;
		@(posedge clk);
		code_sel <= 1'b1;
		src.pulse(1'b0, 1'b1, 8'h3f);
		repeat (8'h08) @(posedge clk);
		check(rst_seen == 0, 1'b1);
		fork
			src.pulse(1'b0, 1'b1, 8'h50);
			begin repeat (8'h04) @(posedge clk); #1 check(force_rst, 1'b1); end
		join
		#1 check(chip_rst, 1'b1);
		repeat (8'h0a) @(posedge clk);
		code_sel <= 1'b0;
		repeat (8'h0a) @(posedge clk);
		#1 check(code_on, 1'b1);
		check(chip_rst | force_rst, 1'b0);
	endtask : t_reset
	task automatic t_nmi;
		src.pulse(1'b1, 1'b1, 8'h17);
		src.pulse(1'b1, 1'b0, 8'h28);
		repeat (8'h08) @(posedge clk);
		check(npulse == 0, 1'b1);
		fork
			src.pulse(1'b1, 1'b1, 8'h1e);
			begin
				repeat (8'h04) @(posedge clk);
				ce <= 1'b0;
				repeat (8'h08) @(posedge clk);
				ce <= 1'b1;
			end
		join
		repeat (8'h08) @(posedge clk);
		check(npulse == 0, 1'b1);
		src.pulse(1'b1, 1'b1, 8'h1e);
		repeat (8'h08) @(posedge clk);
		check(npulse == 1, 1'b1);
	endtask : t_nmi
	task automatic t_wake(input logic pd);
		@(posedge clk);
		idle_req <= !pd;
		pdown_req <= pd;
		repeat (8'h03) @(posedge clk);
		#1 check(pd ? pdown : idle, 1'b1);
		src.pulse(1'b0, 1'b1, 8'h50);
		#1 check(idle | pdown, 1'b0);
		check(code_on, 1'b0);
		@(posedge clk);
		idle_req <= 1'b0;
		pdown_req <= 1'b0;
		repeat (8'h0a) @(posedge clk);
	endtask : t_wake
	initial begin
		repeat (8'h04) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_nmi();
		t_wake(1'b0);
		t_wake(1'b1);
		tally_and_finish();
	end
endmodule : reset_and_nmi_pin_qualifier_test
`default_nettype wire
